//--- logic/dmi_unit.sv
// Data-move instruction unit with an Avalon-MM register port
//
// Function
// - Indirect load copies selected window into accumulator
// - Windows redirect to memory at pointer address
// - Address: pointer, plus one, minus one, plus offset
// - Pointer afterwards: plus one, minus one, unchanged
// - Update code selects pre/post increment/decrement
// - Sixteen-bit pointer wraps modulo full range
// - Bank literal loads six bits, flags untouched
// - Latch literal loads seven bits, flags untouched
// - Accumulator literal loads eight bits, two wait cycles
// - Unused literal bits are taken as zero
// - Store writes accumulator to file register
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
`include "dmi_defs.svh"
module dmi_unit
  import dmi_pkg::*;
#(
  parameter int PTR_W = 16,
  parameter int ADDR_W = 8
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Data memory port
  output logic [PTR_W-1:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata,
  // Core state seen by the rest of the core
  output logic [7:0] o_acc,
  output logic [`DMI_BANK_W-1:0] o_bank_select_reg,
  output logic [`DMI_PCHI_W-1:0] o_program_counter_high_latch,
  output logic o_zero_flag
);
  // ==========================
  // Reset synchroniser
  logic rst_meta_q; // First stage, read only by the second
  logic rst_n_q; // Synchronised reset, active low

  // Release reset through two flops
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================
  // State declarations
  dmi_state_t state_q; // Bus sequencer state
  logic [31:0] cmd_q; // Last command word
  logic [7:0] acc_q; // Accumulator
  logic [`DMI_BANK_W-1:0] bank_q; // Bank select register
  logic [`DMI_PCHI_W-1:0] pchi_q; // Program counter high latch
  logic zero_q; // Zero status flag
  logic [PTR_W-1:0] ptr_q [2]; // Two indirect pointers
  logic [PTR_W-1:0] ptr_next_q; // Pointer value to commit
  logic [PTR_W-1:0] mem_addr_q; // Registered memory address
  logic [31:0] rdata_q; // Registered read data

  // ==========================
  // Register map, byte offsets
  // 0x00 command word, a write runs it
  // 0x04 accumulator, read and write
  // 0x08 status, zero flag in bit 0, read only
  // 0x0c bank select, read only
  // 0x10 program counter high latch, read only
  // 0x14 and 0x18 the two pointers, read and write
  // Other places read as zero and drop writes
  // Byte offsets whose two low bits are ignored

  // ==========================
  // Bus request decode
  logic req; // Any request present
  logic accept; // Request completes this edge
  logic [ADDR_W-1:0] word_addr; // Address with byte bits dropped
  logic hit_cmd; // Command register selected
  logic hit_acc; // Accumulator selected
  logic hit_ptr0; // Pointer 0 selected
  logic hit_ptr1; // Pointer 1 selected
  logic [31:0] wmerge_cmd; // Command after byte lanes
  logic [31:0] wmerge_acc; // Accumulator after byte lanes
  logic [31:0] wmerge_p0; // Pointer 0 after byte lanes
  logic [31:0] wmerge_p1; // Pointer 1 after byte lanes

  // Merge write data into an old word per byte lane
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Handshake: answer only in the acknowledge cycle
  assign req = i_avs_read | i_avs_write;
  assign accept = req && (state_q == DMI_ST_ACK);
  assign o_avs_waitrequest = req && !accept;
  // Register selection on the word address
  assign word_addr = {i_avs_address[ADDR_W-1:2], 2'b00};
  assign hit_cmd = (word_addr == ADDR_W'(`DMI_OFF_CMD));
  assign hit_acc = (word_addr == ADDR_W'(`DMI_OFF_ACC));
  assign hit_ptr0 = (word_addr == ADDR_W'(`DMI_OFF_PTR0));
  assign hit_ptr1 = (word_addr == ADDR_W'(`DMI_OFF_PTR1));
  // Write data merged lane by lane into each target
  assign wmerge_cmd = lane_merge(cmd_q, i_avs_writedata, i_avs_byteenable);
  assign wmerge_acc = lane_merge({24'h000000, acc_q}, i_avs_writedata, i_avs_byteenable);
  assign wmerge_p0 = lane_merge(32'(ptr_q[0]), i_avs_writedata, i_avs_byteenable);
  assign wmerge_p1 = lane_merge(32'(ptr_q[1]), i_avs_writedata, i_avs_byteenable);

  // ==========================
  // Command decode, from the incoming word
  dmi_op_t in_op; // Operation of a new command
  logic in_idx; // Pointer index of a new command
  logic [7:0] in_k; // Literal field of a new command
  logic [PTR_W-1:0] in_ptr; // Selected pointer value
  logic [PTR_W-1:0] ind_addr; // Indirect effective address
  logic [PTR_W-1:0] ind_next; // Indirect pointer after move
  logic [`DMI_FILE_W-1:0] in_file; // File operand of a store
  logic [PTR_W-1:0] store_addr; // Memory address of a store

  // Fields of the word now on the bus
  assign in_op = dmi_op_t'(wmerge_cmd[`DMI_CMD_OP_MSB:`DMI_CMD_OP_LSB]);
  assign in_idx = wmerge_cmd[`DMI_CMD_IDX];
  assign in_k = wmerge_cmd[`DMI_CMD_K_MSB:`DMI_CMD_K_LSB];
  assign in_ptr = ptr_q[in_idx];
  assign in_file = in_k[`DMI_FILE_W-1:0];

  // Pointer arithmetic for the selected window
  dmi_ptr_calc #(
    .PTR_W(PTR_W),
    .OFFS_W(`DMI_OFFS_W)
  ) u_ptr_calc (
    .i_ptr(in_ptr),
    .i_mode(wmerge_cmd[`DMI_CMD_MODE_MSB:`DMI_CMD_MODE_LSB]),
    .i_rel(wmerge_cmd[`DMI_CMD_REL]),
    .i_offs(in_k[`DMI_OFFS_W-1:0]),
    .o_addr(ind_addr),
    .o_next(ind_next)
  );

  // Store address: windows redirect through their pointer
  always_comb begin
    if (in_file == `DMI_WIN0) begin
      store_addr = ptr_q[0];
    end else if (in_file == `DMI_WIN1) begin
      store_addr = ptr_q[1];
    end else begin
      store_addr = PTR_W'({bank_q, in_file});
    end
  end

  // ==========================
  // Latched command fields
  dmi_op_t op_q; // Operation in flight
  logic idx_q; // Pointer index in flight
  logic [7:0] k_q; // Literal in flight

  // Fields of the command in flight
  assign op_q = dmi_op_t'(cmd_q[`DMI_CMD_OP_MSB:`DMI_CMD_OP_LSB]);
  assign idx_q = cmd_q[`DMI_CMD_IDX];
  assign k_q = cmd_q[`DMI_CMD_K_MSB:`DMI_CMD_K_LSB];

  // ==========================
  // Bus sequencer
  // Plain register access: one wait cycle
  //   Request seen in idle, answered in the acknowledge cycle
  //   Read data captured at the idle edge, stands afterwards
  // Command write: two wait cycles
  //   Idle edge latches the word, the address and the new pointer
  //   Execute cycle strobes the memory read of an indirect load
  //   Acknowledge cycle sees the read byte and strobes a store
  //   Acknowledge edge commits accumulator, flag, pointer, literals
  // Memory address holds from execute through acknowledge
  // A held request starts over from idle after each answer
  // Unknown operation codes take the same path and change nothing
  // State register; falls back to idle from any stray code
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= DMI_ST_IDLE;
    end else begin
      unique case (state_q)
        DMI_ST_IDLE: begin
          // Command writes run through the execute cycle
          if (i_avs_write && hit_cmd) begin
            state_q <= DMI_ST_EXEC;
          end else if (req) begin
            state_q <= DMI_ST_ACK;
          end
        end
        DMI_ST_EXEC: begin
          // Memory data valid in the following cycle
          state_q <= DMI_ST_ACK;
        end
        DMI_ST_ACK: begin
          state_q <= DMI_ST_IDLE;
        end
        // Unused code returns to idle
        default: begin
          state_q <= DMI_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================
  // Command capture and address setup
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_q <= 32'h00000000;
      mem_addr_q <= `DMI_PTR_RST;
      ptr_next_q <= `DMI_PTR_RST;
    end else if (state_q == DMI_ST_IDLE && i_avs_write && hit_cmd) begin
      cmd_q <= wmerge_cmd;
      ptr_next_q <= ind_next;
      if (in_op == DMI_OP_STORE) begin
        mem_addr_q <= store_addr;
      end else begin
        mem_addr_q <= ind_addr;
      end
    end
  end

  // ==========================
  // Memory strobes
  // Address straight from its register
  assign o_mem_addr = mem_addr_q;
  // Read strobe only in the execute cycle of an indirect load
  assign o_mem_rd = (state_q == DMI_ST_EXEC) && (op_q == DMI_OP_ILOAD);
  // Write strobe only when a store command is answered, never on a read
  assign o_mem_wr = accept && i_avs_write && hit_cmd && (op_q == DMI_OP_STORE);
  // Store data is the accumulator itself
  assign o_mem_wdata = acc_q;

  // ==========================
  // Command commit qualifier
  logic commit; // Command write completes now
  assign commit = accept && i_avs_write && hit_cmd;

  // ==========================
  // Accumulator
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      acc_q <= `DMI_ACC_RST;
    end else if (commit) begin
      unique case (op_q)
        DMI_OP_ILOAD: acc_q <= i_mem_rdata;
        DMI_OP_LIT_ACC: acc_q <= k_q;
        default: acc_q <= acc_q;
      endcase
    end else if (accept && i_avs_write && hit_acc) begin
      acc_q <= wmerge_acc[7:0];
    end
  end

  // ==========================
  // Zero flag, touched only by indirect load
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      zero_q <= 1'b0;
    end else if (commit && op_q == DMI_OP_ILOAD) begin
      zero_q <= (i_mem_rdata == 8'h00);
    end
  end

  // ==========================
  // Bank select and program latch literals
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bank_q <= '0;
      pchi_q <= '0;
    end else if (commit) begin
      if (op_q == DMI_OP_LIT_BANK) begin
        bank_q <= k_q[`DMI_BANK_W-1:0];
      end
      if (op_q == DMI_OP_LIT_PCHI) begin
        pchi_q <= k_q[`DMI_PCHI_W-1:0];
      end
    end
  end

  // ==========================
  // Indirect pointers
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ptr_q[0] <= `DMI_PTR_RST;
      ptr_q[1] <= `DMI_PTR_RST;
    end else if (commit && op_q == DMI_OP_ILOAD) begin
      ptr_q[idx_q] <= ptr_next_q;
    end else if (accept && i_avs_write && hit_ptr0) begin
      ptr_q[0] <= wmerge_p0[PTR_W-1:0];
    end else if (accept && i_avs_write && hit_ptr1) begin
      ptr_q[1] <= wmerge_p1[PTR_W-1:0];
    end
  end

  // ==========================
  // Read data, captured one cycle before the answer
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 32'h00000000;
    end else if (state_q == DMI_ST_IDLE && i_avs_read) begin
      unique case (word_addr)
        ADDR_W'(`DMI_OFF_CMD): rdata_q <= cmd_q;
        ADDR_W'(`DMI_OFF_ACC): rdata_q <= {24'h000000, acc_q};
        ADDR_W'(`DMI_OFF_STAT): rdata_q <= {30'h0, 1'b0, zero_q};
        ADDR_W'(`DMI_OFF_BANK): rdata_q <= 32'(bank_q);
        ADDR_W'(`DMI_OFF_PCHI): rdata_q <= 32'(pchi_q);
        ADDR_W'(`DMI_OFF_PTR0): rdata_q <= 32'(ptr_q[0]);
        ADDR_W'(`DMI_OFF_PTR1): rdata_q <= 32'(ptr_q[1]);
        // Unmapped addresses read as zero
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // ==========================
  // Outputs
  assign o_avs_readdata = rdata_q;
  assign o_acc = acc_q;
  assign o_bank_select_reg = bank_q;
  assign o_program_counter_high_latch = pchi_q;
  assign o_zero_flag = zero_q;
endmodule : dmi_unit

//--- logic/dmi_defs.svh
// Offsets, field positions, reset values and timing counts for the data-move unit
`ifndef DMI_DEFS_SVH
`define DMI_DEFS_SVH
// ==========================
// Register byte offsets
`define DMI_OFF_CMD 8'h00
`define DMI_OFF_ACC 8'h04
`define DMI_OFF_STAT 8'h08
`define DMI_OFF_BANK 8'h0c
`define DMI_OFF_PCHI 8'h10
`define DMI_OFF_PTR0 8'h14
`define DMI_OFF_PTR1 8'h18
// ==========================
// Command word fields
`define DMI_CMD_OP_LSB 0
`define DMI_CMD_OP_MSB 2
`define DMI_CMD_IDX 3
`define DMI_CMD_MODE_LSB 4
`define DMI_CMD_MODE_MSB 5
`define DMI_CMD_REL 6
`define DMI_CMD_K_LSB 8
`define DMI_CMD_K_MSB 15
// ==========================
// Status fields
`define DMI_STAT_ZERO 0
`define DMI_STAT_BUSY 1
// ==========================
// Widths and reset values
`define DMI_BANK_W 6
`define DMI_PCHI_W 7
`define DMI_FILE_W 7
`define DMI_OFFS_W 6
`define DMI_ACC_RST 8'h00
`define DMI_PTR_RST 16'h0000
`define DMI_WIN0 7'h00
`define DMI_WIN1 7'h01
// ==========================
// Timing: memory read data follows the read strobe by this many cycles
`define DMI_MEM_LAT 1
`endif

//--- logic/dmi_pkg.sv
// Types shared by the data-move unit
package dmi_pkg;
  // Operation selected by the command word
  typedef enum logic [2:0] {
    DMI_OP_ILOAD = 3'h0,
    DMI_OP_LIT_BANK = 3'h1,
    DMI_OP_LIT_PCHI = 3'h2,
    DMI_OP_LIT_ACC = 3'h3,
    DMI_OP_STORE = 3'h4
  } dmi_op_t;
  // Pointer update code
  typedef enum logic [1:0] {
    DMI_PRE_INC = 2'h0,
    DMI_PRE_DEC = 2'h1,
    DMI_POST_INC = 2'h2,
    DMI_POST_DEC = 2'h3
  } dmi_mode_t;
  // Bus sequencer states
  typedef enum logic [1:0] {
    DMI_ST_IDLE,
    DMI_ST_EXEC,
    DMI_ST_ACK
  } dmi_state_t;
endpackage : dmi_pkg

//--- logic/dmi_ptr_calc.sv
// Effective address and updated value of one indirect pointer
`timescale 1ns/1ns
`include "dmi_defs.svh"
module dmi_ptr_calc
  import dmi_pkg::*;
#(
  parameter int PTR_W = 16,
  parameter int OFFS_W = `DMI_OFFS_W
) (
  input wire logic [PTR_W-1:0] i_ptr,
  input wire logic [1:0] i_mode,
  input wire logic i_rel,
  input wire logic [OFFS_W-1:0] i_offs,
  output logic [PTR_W-1:0] o_addr,
  output logic [PTR_W-1:0] o_next
);
  // ==========================
  // Neighbours and signed offset
  logic [PTR_W-1:0] plus_one; // Old pointer plus one
  logic [PTR_W-1:0] minus_one; // Old pointer minus one
  logic [PTR_W-1:0] offs_ext; // Offset sign-extended
  logic [PTR_W-1:0] rel_addr; // Pointer plus offset

  // Modular arithmetic, carry out dropped on purpose
  assign plus_one = PTR_W'(i_ptr + 1'b1);
  assign minus_one = PTR_W'(i_ptr - 1'b1);
  assign offs_ext = {{(PTR_W-OFFS_W){i_offs[OFFS_W-1]}}, i_offs};
  assign rel_addr = PTR_W'(i_ptr + offs_ext);

  // ==========================
  // Address and pointer selection
  always_comb begin
    o_addr = i_ptr;
    o_next = i_ptr;
    if (i_rel) begin
      // Relative form leaves the pointer alone
      o_addr = rel_addr;
      o_next = i_ptr;
    end else begin
      unique case (dmi_mode_t'(i_mode))
        DMI_PRE_INC: begin
          o_addr = plus_one;
          o_next = plus_one;
        end
        DMI_PRE_DEC: begin
          o_addr = minus_one;
          o_next = minus_one;
        end
        DMI_POST_INC: begin
          o_addr = i_ptr;
          o_next = plus_one;
        end
        DMI_POST_DEC: begin
          o_addr = i_ptr;
          o_next = minus_one;
        end
      endcase
    end
  end
endmodule : dmi_ptr_calc

//--- bench/dmi_mem_model.sv
// Data memory model facing the data-move unit
`timescale 1ns/1ns
module dmi_mem_model (
  input wire logic i_mclk,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  // Bytes left by stores
  logic [7:0] mem [int];
  // Stored byte, else a pattern made from the address
  function automatic logic [7:0] peek(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8];
  endfunction : peek
  initial o_rdata = 8'h00;
  // One cycle read latency; the line wanders otherwise
  always @(posedge i_mclk) begin
    if (i_rd) begin
      o_rdata <= peek(i_addr);
    end else begin
      o_rdata <= ~o_rdata;
    end
    // Store lands at the strobe edge
    if (i_wr) begin
      mem[i_addr] = i_wdata;
    end
  end
endmodule : dmi_mem_model

//--- bench/dmi_unit_checker.sv
// Port assertions for the data-move unit
`timescale 1ns/1ns
`include "dmi_defs.svh"
module dmi_unit_checker
  import dmi_pkg::*;
#(
  parameter int PTR_W = 16,
  parameter int ADDR_W = 8
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  input wire logic [PTR_W-1:0] o_mem_addr,
  input wire logic o_mem_rd,
  input wire logic o_mem_wr,
  input wire logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [7:0] o_acc,
  input wire logic [`DMI_BANK_W-1:0] o_bank_select_reg,
  input wire logic [`DMI_PCHI_W-1:0] o_program_counter_high_latch,
  input wire logic o_zero_flag
);
  // ==========================
  // Command accept decode
  logic cmd_ok;
  dmi_op_t op;
  assign cmd_ok = i_avs_write && !o_avs_waitrequest && i_avs_address[7:2] == 6'h00;
  assign op = dmi_op_t'(i_avs_writedata[2:0]);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  // ==========================
  // Properties
  property p_lit_acc;
    cmd_ok && op == DMI_OP_LIT_ACC |=> o_acc == $past(i_avs_writedata[15:8]) && $stable(o_zero_flag);
  endproperty
  a_lit_acc: assert property (p_lit_acc) else $error("acc literal wrong");
  property p_lit_bank;
    cmd_ok && op == DMI_OP_LIT_BANK |=> o_bank_select_reg == $past(i_avs_writedata[13:8]) && $stable(o_zero_flag);
  endproperty
  a_lit_bank: assert property (p_lit_bank) else $error("bank literal wrong");
  property p_lit_pchi;
    cmd_ok && op == DMI_OP_LIT_PCHI |=> o_program_counter_high_latch == $past(i_avs_writedata[14:8]) &&
      $stable(o_zero_flag);
  endproperty
  a_lit_pchi: assert property (p_lit_pchi) else $error("latch literal wrong");
  property p_iload_acc;
    cmd_ok && op == DMI_OP_ILOAD |-> $past(o_mem_rd) ##1 o_acc == $past(i_mem_rdata);
  endproperty
  a_iload_acc: assert property (p_iload_acc) else $error("indirect load data wrong");
  property p_iload_zero;
    cmd_ok && op == DMI_OP_ILOAD |=> o_zero_flag == (o_acc == 8'h00);
  endproperty
  a_iload_zero: assert property (p_iload_zero) else $error("zero flag wrong");
  property p_rd_pulse;
    o_mem_rd |=> !o_mem_rd && !o_avs_waitrequest && $stable(o_mem_addr);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("memory read strobe wrong");
  property p_store;
    cmd_ok && op == DMI_OP_STORE |-> o_mem_wr && o_mem_wdata == o_acc ##1 $stable(o_zero_flag);
  endproperty
  a_store: assert property (p_store) else $error("store wrong");
  property p_wr_only;
    o_mem_wr |-> i_avs_write && !o_avs_waitrequest;
  endproperty
  a_wr_only: assert property (p_wr_only) else $error("memory write outside a store");
  property p_cmd_wait;
    $rose(i_avs_write) && i_avs_address[7:2] == 6'h00 |-> o_avs_waitrequest [*2] ##1 !o_avs_waitrequest;
  endproperty
  a_cmd_wait: assert property (p_cmd_wait) else $error("command timing wrong");
  // Main scenarios reached
  c_iload: cover property (cmd_ok && op == DMI_OP_ILOAD && o_zero_flag);
  c_store: cover property (cmd_ok && op == DMI_OP_STORE);
  c_rel: cover property (cmd_ok && op == DMI_OP_ILOAD && i_avs_writedata[6]);
endmodule : dmi_unit_checker
bind dmi_unit dmi_unit_checker #(.PTR_W(PTR_W), .ADDR_W(ADDR_W)) u_dmi_unit_checker (.*);

//--- bench/testbench.sv
// Self-checking bench for the data-move unit
`timescale 1ns/1ns
module testbench;
  import dmi_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic [31:0] seed = 32'hb24d0f11;
  logic wreq, mrd, mwr, z;
  logic [7:0] mwd, mrdata, k, d;
  logic [15:0] maddr, p, ea, np, a;
  logic [1:0] upd_code;
  logic [6:0] f;
  logic [31:0] expq [$];
  int err_total = 0;
  int num_checks = 0;
  dmi_unit u_dmi_unit (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_mem_addr(maddr), .o_mem_rd(mrd), .o_mem_wr(mwr), .o_mem_wdata(mwd),
    .i_mem_rdata(mrdata), .o_acc(), .o_bank_select_reg(), .o_program_counter_high_latch(), .o_zero_flag());
  dmi_mem_model u_dmi_mem_model (.i_mclk(i_mclk), .i_addr(maddr), .i_rd(mrd), .i_wr(mwr), .i_wdata(mwd),
    .o_rdata(mrdata));
  always #5 i_mclk = ~i_mclk;
  // ==========================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // One Avalon transfer, held until waitrequest drops
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    @(posedge i_mclk);
    wr <= w;
    rd <= !w;
    adr <= ad;
    wd <= dt;
    do @(posedge i_mclk); while (wreq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // Read with its expected word noted first
  task automatic rdx(input logic [7:0] ad, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, ad, 32'h0);
  endtask : rdx
  task automatic cmd(input logic [2:0] op, input logic [7:0] lit, input logic idx = 1'b0,
                     input logic [1:0] md = 2'h0, input logic rel = 1'b0);
    bus(1'b1, 8'h00, {16'h0, lit, 1'b0, rel, md, idx, op});
  endtask : cmd
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: read %h, wanted %h", $time, g, e);
    end
  endtask : cmp
  task automatic end_sim();
    // Notes never matched by a result count against the run
    if (expq.size() != 0) begin
      err_total++;
    end
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // Monitor: oldest note against each accepted read
  always @(posedge i_mclk) begin
    if (rd && wreq === 1'b0) begin
      cmp(rdata, expq.size() > 0 ? expq.pop_front() : 32'hx);
    end
  end
  // Watchdog
  initial begin
    #300000;
    err_total++;
    end_sim();
  end
  // ==========================
  // Main sequence
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_mclk);
    // Reset values, read-only and unmapped places
    bus(1'b1, 8'h08, 32'hffffffff);
    bus(1'b1, 8'h1c, 32'hffffffff);
    for (int i = 0; i < 8; i++) begin
      rdx(8'(i * 4), 32'h0);
    end
    $display("reset test done");
    // Indirect loads: four update codes plus relative, pointer edges
    for (int n = 0; n < 2; n++) begin
      for (int m = 0; m < 5; m++) begin
        for (int j = 0; j < 3; j++) begin
          p = (j == 0) ? 16'hffff : (j == 1) ? 16'h0000 : 16'(rnd());
          k = (m < 4) ? 8'h00 : (j == 0) ? 8'h20 : (j == 1) ? 8'h1f : {2'b00, 6'(rnd())};
          upd_code = (m < 4) ? 2'(m) : 2'(rnd());
          np = (m == 4) ? p : (m % 2 == 1) ? p - 16'h1 : p + 16'h1;
          ea = (m == 4) ? p + {{10{k[5]}}, k[5:0]} : (m >= 2) ? p : np;
          d = u_dmi_mem_model.peek(ea);
          z = (d == 8'h00);
          bus(1'b1, 8'h14 + 8'(n * 4), {16'h0, p});
          cmd(DMI_OP_ILOAD, k, n[0], upd_code, m == 4);
          rdx(8'h04, {24'h0, d});
          rdx(8'h14 + 8'(n * 4), {16'h0, np});
          rdx(8'h08, {31'h0, z});
          cmd(DMI_OP_LIT_ACC, 8'(rnd()));
          rdx(8'h08, {31'h0, z});
        end
      end
    end
    $display("indirect load test done");
    // Literals with random upper bits
    for (int i = 0; i < 6; i++) begin
      k = (i == 0) ? 8'h00 : 8'(rnd());
      cmd(DMI_OP_LIT_ACC, k);
      rdx(8'h04, {24'h0, k});
      cmd(DMI_OP_LIT_BANK, k);
      rdx(8'h0c, {26'h0, k[5:0]});
      cmd(DMI_OP_LIT_PCHI, k);
      rdx(8'h10, {25'h0, k[6:0]});
      rdx(8'h08, {31'h0, z});
    end
    $display("literal test done");
    // Stores through both windows and through the bank, read back
    cmd(DMI_OP_LIT_BANK, 8'h2b);
    for (int s = 0; s < 3; s++) begin
      f = (s == 2) ? 7'h7f : 7'(s);
      d = 8'(rnd());
      a = (s == 2) ? {3'b000, 6'h2b, f} : 16'h4000 + 16'(s * 'h111);
      if (s < 2) bus(1'b1, 8'h14 + 8'(s * 4), {16'h0, a});
      cmd(DMI_OP_LIT_ACC, d);
      cmd(DMI_OP_STORE, {1'b0, f});
      rdx(8'h08, {31'h0, z});
      cmd(DMI_OP_LIT_ACC, ~d);
      bus(1'b1, 8'h18, {16'h0, a});
      cmd(DMI_OP_ILOAD, 8'h00, 1'b1, 2'h2);
      rdx(8'h04, {24'h0, d});
      z = (d == 8'h00);
    end
    $display("store test done");
    repeat (4) @(posedge i_mclk);
    end_sim();
  end
endmodule : testbench
